// >>> hdl/sfpx_unit.sv
/*
 SIMD floating-point exception unit: control/status register, sticky
 flags, masks, fault delivery, denormal flush and AXI4-Lite slave.
 Assumes completion reports and operands synchronous to REF_CLK_IN.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfpx_defines.svh"

// Operation
// - six classes: invalid, divide-by-zero, denormal, overflow, underflow, inexact.
// - each class has its own flag and mask in the control/status register.
// - exceptions are precise, reported right when the instruction completes; here FAULT_OUT shows the fault one edge after completion.
// - packed integer ops never raise numeric exceptions; only fp ops may.
// - memory and non-numeric faults use the ordinary exception path.
// - masks written by load/restore; flags and masks read by store/save.
// - unmasked condition with os handler bit 10 set gives the simd fault.
// - os handler bit clear gives a bad-opcode fault instead.
// - the x87 truncating store never raises simd exceptions.
// - invalid flag is bit 0, invalid mask bit 7.
// - denormal flag is bit 1, denormal mask bit 8.
// - unmasked invalid suppresses destination writeback, operands unchanged.
// - with bit 6 set, denormal sources become signed zeros.
module sfpx_unit (
  input  wire logic                    REF_CLK_IN,
  input  wire logic                    RST_N_IN,
  input  wire logic [`SFPX_ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic                    S_AXI_AWVALID_IN,
  output logic                         S_AXI_AWREADY_OUT,
  input  wire logic [31:0]             S_AXI_WDATA_IN,
  input  wire logic [3:0]              S_AXI_WSTRB_IN,
  input  wire logic                    S_AXI_WVALID_IN,
  output logic                         S_AXI_WREADY_OUT,
  output logic [1:0]                   S_AXI_BRESP_OUT,
  output logic                         S_AXI_BVALID_OUT,
  input  wire logic                    S_AXI_BREADY_IN,
  input  wire logic [`SFPX_ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic                    S_AXI_ARVALID_IN,
  output logic                         S_AXI_ARREADY_OUT,
  output logic [31:0]                  S_AXI_RDATA_OUT,
  output logic [1:0]                   S_AXI_RRESP_OUT,
  output logic                         S_AXI_RVALID_OUT,
  input  wire logic                    S_AXI_RREADY_IN,
  input  wire sfpx_pkg::sfpx_cmpl_s    CMPL_IN,
  input  wire sfpx_pkg::sfpx_load_s    CORE_LOAD_IN,
  output logic [31:0]                  CORE_STORE_OUT,
  input  wire logic [31:0]             SRC_OPND_IN,
  output logic [31:0]                  SRC_FLUSHED_OUT,
  output sfpx_pkg::sfpx_fault_s        FAULT_OUT,
  output logic                         IRQ_OUT
);

  logic [`SFPX_NUM_EXC-1:0] flags_reg;
  logic [`SFPX_NUM_EXC-1:0] flags_next;
  logic [`SFPX_NUM_EXC-1:0] masks_reg;
  logic [`SFPX_NUM_EXC-1:0] masks_next;
  logic                     daz_reg;
  logic                     daz_next;
  logic                     os_ok_reg;
  logic [`SFPX_IRQ_W-1:0]   irq_st_reg;
  logic [`SFPX_IRQ_W-1:0]   irq_msk_reg;
  logic [`SFPX_IRQ_W-1:0]   irq_set;
  logic                     bvalid_reg;
  logic [1:0]               bresp_reg;
  logic                     rvalid_reg;
  logic [1:0]               rresp_reg;
  logic [31:0]              rdata_reg;
  logic [31:0]              flush_reg;
  sfpx_pkg::sfpx_fault_s    fault_reg;
  logic [`SFPX_NUM_EXC-1:0] cond_set;
  logic [`SFPX_NUM_EXC-1:0] unmasked;
  logic                     any_unm;
  logic                     wr_go;
  logic                     rd_go;
  logic [31:0]              ctrl_word;
  logic [31:0]              ctrl_merged;

  function automatic logic addr_hit(input logic [`SFPX_ADDR_W-1:0] a,
                                    input logic [`SFPX_ADDR_W-1:0] off);
    addr_hit = a == off;
  endfunction

  function automatic logic mapped(input logic [`SFPX_ADDR_W-1:0] a);
    mapped = addr_hit(a, `SFPX_OFF_CTRL) || addr_hit(a, `SFPX_OFF_SYSC4) ||
             addr_hit(a, `SFPX_OFF_IRQ_ST) || addr_hit(a, `SFPX_OFF_IRQ_MSK);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // denormal single: zero exponent, nonzero fraction
  function automatic logic [31:0] daz32(input logic [31:0] v);
    if (v[30:23] == 8'h00 && v[22:0] != 23'h000000) begin
      daz32 = {v[31], 31'h00000000};
    end else begin
      daz32 = v;
    end
  endfunction

  // layout: flags, denormals-as-zero, masks; bits above read zero
  assign ctrl_word = {19'h00000, masks_reg, daz_reg, flags_reg};

  sfpx_filter u_filter (
    .clk_in       (REF_CLK_IN),
    .rst_n_in     (RST_N_IN),
    .cmpl_in      (CMPL_IN),
    .mask_in      (masks_reg),
    .cond_out     (cond_set),
    .unmasked_out (unmasked)
  );

  assign any_unm = |unmasked;

  // bus handshake: write address and data taken together
  assign wr_go = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !bvalid_reg;
  assign rd_go = S_AXI_ARVALID_IN && !rvalid_reg;
  assign S_AXI_AWREADY_OUT = wr_go;
  assign S_AXI_WREADY_OUT  = wr_go;
  assign S_AXI_ARREADY_OUT = rd_go;
  assign S_AXI_BVALID_OUT  = bvalid_reg;
  assign S_AXI_BRESP_OUT   = bresp_reg;
  assign S_AXI_RVALID_OUT  = rvalid_reg;
  assign S_AXI_RRESP_OUT   = rresp_reg;
  assign S_AXI_RDATA_OUT   = rdata_reg;

  assign ctrl_merged = merge(ctrl_word, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);

  // core load beats a bus write; a new condition beats both
  always_comb begin
    flags_next = flags_reg;
    masks_next = masks_reg;
    daz_next   = daz_reg;
    if (CORE_LOAD_IN.en) begin
      flags_next = CORE_LOAD_IN.data[`SFPX_BIT_INX:`SFPX_BIT_INV];
      masks_next = CORE_LOAD_IN.data[`SFPX_MASK_MSB:`SFPX_MASK_LSB];
      daz_next   = CORE_LOAD_IN.data[`SFPX_BIT_DAZ];
    end else if (wr_go && addr_hit(S_AXI_AWADDR_IN, `SFPX_OFF_CTRL)) begin
      flags_next = ctrl_merged[`SFPX_BIT_INX:`SFPX_BIT_INV];
      masks_next = ctrl_merged[`SFPX_MASK_MSB:`SFPX_MASK_LSB];
      daz_next   = ctrl_merged[`SFPX_BIT_DAZ];
    end
    flags_next = flags_next | cond_set;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      flags_reg <= '0;
      masks_reg <= `SFPX_MASK_RST;
      daz_reg   <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      masks_reg <= masks_next;
      daz_reg   <= daz_next;
    end
  end

  assign CORE_STORE_OUT = ctrl_word;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      os_ok_reg <= 1'b0;
    end else if (wr_go && addr_hit(S_AXI_AWADDR_IN, `SFPX_OFF_SYSC4) &&
                 S_AXI_WSTRB_IN[1]) begin
      os_ok_reg <= S_AXI_WDATA_IN[`SFPX_BIT_OSOK];
    end
  end

  // delivery one edge after completion, tied to that instruction
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      fault_reg <= '0;
    end else begin
      fault_reg.xf     <= any_unm && os_ok_reg;
      fault_reg.ud     <= any_unm && !os_ok_reg;
      fault_reg.nonnum <= CMPL_IN.valid && CMPL_IN.nonnum;
      fault_reg.wb_en  <= CMPL_IN.valid && !CMPL_IN.nonnum &&
                          !unmasked[`SFPX_BIT_INV];
    end
  end
  assign FAULT_OUT = fault_reg;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      flush_reg <= '0;
    end else begin
      flush_reg <= daz_reg ? daz32(SRC_OPND_IN) : SRC_OPND_IN;
    end
  end
  assign SRC_FLUSHED_OUT = flush_reg;

  // interrupt: sticky events, read of the status word clears all but events of that same cycle
  assign irq_set = {CMPL_IN.valid && CMPL_IN.nonnum,
                    any_unm && !os_ok_reg, any_unm && os_ok_reg};

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      irq_st_reg <= '0;
    end else if (rd_go && addr_hit(S_AXI_ARADDR_IN, `SFPX_OFF_IRQ_ST)) begin
      irq_st_reg <= irq_set;
    end else begin
      irq_st_reg <= irq_st_reg | irq_set;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      irq_msk_reg <= '0;
    end else if (wr_go && addr_hit(S_AXI_AWADDR_IN, `SFPX_OFF_IRQ_MSK) &&
                 S_AXI_WSTRB_IN[0]) begin
      irq_msk_reg <= S_AXI_WDATA_IN[`SFPX_IRQ_W-1:0];
    end
  end
  assign IRQ_OUT = |(irq_st_reg & irq_msk_reg);

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `SFPX_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= mapped(S_AXI_AWADDR_IN) ? `SFPX_RESP_OKAY
                                            : `SFPX_RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `SFPX_RESP_OKAY;
      rdata_reg  <= '0;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= mapped(S_AXI_ARADDR_IN) ? `SFPX_RESP_OKAY
                                            : `SFPX_RESP_SLVERR;
      rdata_reg  <= '0;
      if (addr_hit(S_AXI_ARADDR_IN, `SFPX_OFF_CTRL)) begin
        rdata_reg <= ctrl_word;
      end else if (addr_hit(S_AXI_ARADDR_IN, `SFPX_OFF_SYSC4)) begin
        rdata_reg[`SFPX_BIT_OSOK] <= os_ok_reg;
      end else if (addr_hit(S_AXI_ARADDR_IN, `SFPX_OFF_IRQ_ST)) begin
        rdata_reg[`SFPX_IRQ_W-1:0] <= irq_st_reg;
      end else if (addr_hit(S_AXI_ARADDR_IN, `SFPX_OFF_IRQ_MSK)) begin
        rdata_reg[`SFPX_IRQ_W-1:0] <= irq_msk_reg;
      end
    end else if (S_AXI_RREADY_IN) begin
      rvalid_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  property p_xf_when_ok;
    any_unm && os_ok_reg |=> FAULT_OUT.xf && !FAULT_OUT.ud;
  endproperty
  a_xf_when_ok: assert property (p_xf_when_ok)
    else $error("unmasked condition with os bit set gave no simd fault");

  property p_ud_when_not_ok;
    CMPL_IN.valid && (|(CMPL_IN.cond & ~masks_reg)) && !os_ok_reg &&
    !CMPL_IN.nonnum && CMPL_IN.kind == sfpx_pkg::SFPX_K_FP
    |=> FAULT_OUT.ud && !FAULT_OUT.xf;
  endproperty
  a_ud_when_not_ok: assert property (p_ud_when_not_ok)
    else $error("os bit clear did not give bad opcode fault");

  property p_precise;
    (FAULT_OUT.xf || FAULT_OUT.ud) |-> $past(CMPL_IN.valid);
  endproperty
  a_precise: assert property (p_precise)
    else $error("fault not tied to a completing instruction");

  property p_sticky;
    CMPL_IN.valid && CMPL_IN.kind == sfpx_pkg::SFPX_K_FP && !CMPL_IN.nonnum
    |=> (flags_reg & $past(CMPL_IN.cond)) == $past(CMPL_IN.cond);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("condition did not set its sticky flag");

  property p_inv_no_wb;
    CMPL_IN.valid && CMPL_IN.kind == sfpx_pkg::SFPX_K_FP &&
    CMPL_IN.cond[`SFPX_BIT_INV] && !masks_reg[`SFPX_BIT_INV]
    |=> !FAULT_OUT.wb_en;
  endproperty
  a_inv_no_wb: assert property (p_inv_no_wb)
    else $error("unmasked invalid allowed writeback");

  property p_daz;
    daz_reg && SRC_OPND_IN[30:23] == 8'h00 |=>
    SRC_FLUSHED_OUT[30:0] == 31'h00000000 &&
    SRC_FLUSHED_OUT[31] == $past(SRC_OPND_IN[31]);
  endproperty
  a_daz: assert property (p_daz)
    else $error("denormal source not flushed to signed zero");

  property p_load_masks;
    CORE_LOAD_IN.en |=> CORE_STORE_OUT[`SFPX_MASK_MSB:`SFPX_MASK_LSB] ==
                        $past(CORE_LOAD_IN.data[`SFPX_MASK_MSB:`SFPX_MASK_LSB]);
  endproperty
  a_load_masks: assert property (p_load_masks)
    else $error("core load did not set the masks");

  property p_nonnum;
    CMPL_IN.valid && CMPL_IN.nonnum |=> FAULT_OUT.nonnum && !FAULT_OUT.xf;
  endproperty
  a_nonnum: assert property (p_nonnum)
    else $error("non-numeric fault not passed on its own path");

  c_xf: cover property (FAULT_OUT.xf);
  c_ud: cover property (FAULT_OUT.ud);
  c_daz: cover property (daz_reg && SRC_OPND_IN[30:23] == 8'h00);
  c_irq: cover property (IRQ_OUT ##1 rd_go);

endmodule
`default_nettype wire

// >>> common/sfpx_defines.svh
/*
 Offsets, field positions, reset values and bus codes of the SIMD
 floating-point exception unit. Assumes a 32-bit AXI4-Lite register bus.
*/
`ifndef SFPX_DEFINES_SVH
`define SFPX_DEFINES_SVH

`define SFPX_ADDR_W        8
`define SFPX_OFF_CTRL      8'h00
`define SFPX_OFF_SYSC4     8'h04
`define SFPX_OFF_IRQ_ST    8'h08
`define SFPX_OFF_IRQ_MSK   8'h0c

`define SFPX_NUM_EXC       6
`define SFPX_BIT_INV       0
`define SFPX_BIT_DEN       1
`define SFPX_BIT_ZDIV      2
`define SFPX_BIT_OVF       3
`define SFPX_BIT_UNF       4
`define SFPX_BIT_INX       5
`define SFPX_BIT_DAZ       6
`define SFPX_MASK_LSB      7
`define SFPX_MASK_MSB      12
`define SFPX_BIT_OSOK      10

`define SFPX_MASK_RST      6'h3f
`define SFPX_IRQ_W         3
`define SFPX_IRQ_XF        0
`define SFPX_IRQ_UD        1
`define SFPX_IRQ_NN        2

`define SFPX_RESP_OKAY     2'h0
`define SFPX_RESP_SLVERR   2'h2

`endif

// >>> common/sfpx_pkg.sv
/*
 Types of the SIMD floating-point exception unit.
 Assumes the constants header for widths.
*/
`include "sfpx_defines.svh"

package sfpx_pkg;

  typedef enum logic [1:0] {
    SFPX_K_INT,
    SFPX_K_FP,
    SFPX_K_X87T,
    SFPX_K_OTHER
  } sfpx_kind_e;

  typedef struct packed {
    logic                       valid;
    sfpx_kind_e                 kind;
    logic [`SFPX_NUM_EXC-1:0]   cond;
    logic                       nonnum;
  } sfpx_cmpl_s;

  typedef struct packed {
    logic        en;
    logic [31:0] data;
  } sfpx_load_s;

  typedef struct packed {
    logic xf;
    logic ud;
    logic nonnum;
    logic wb_en;
  } sfpx_fault_s;

endpackage

// >>> hdl/sfpx_filter.sv
/*
 Qualifies raw exception conditions of a completing instruction.
 Assumes one completion report per cycle from the execution core.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfpx_defines.svh"

module sfpx_filter (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire sfpx_pkg::sfpx_cmpl_s     cmpl_in,
  input  wire logic [`SFPX_NUM_EXC-1:0] mask_in,
  output logic [`SFPX_NUM_EXC-1:0]      cond_out,
  output logic [`SFPX_NUM_EXC-1:0]      unmasked_out
);

  logic fp_done;

  // a memory fault stops the instruction before any numeric result
  assign fp_done = cmpl_in.valid && !cmpl_in.nonnum &&
                   cmpl_in.kind == sfpx_pkg::SFPX_K_FP;
  assign cond_out = fp_done ? cmpl_in.cond : '0;
  assign unmasked_out = cond_out & ~mask_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_int_quiet;
    cmpl_in.kind == sfpx_pkg::SFPX_K_INT |-> cond_out == '0;
  endproperty
  a_int_quiet: assert property (p_int_quiet)
    else $error("integer op raised a numeric condition");

  property p_x87t_quiet;
    cmpl_in.kind == sfpx_pkg::SFPX_K_X87T |-> unmasked_out == '0;
  endproperty
  a_x87t_quiet: assert property (p_x87t_quiet)
    else $error("x87 truncating store raised a simd condition");

  property p_six_pass;
    fp_done |-> cond_out == cmpl_in.cond;
  endproperty
  a_six_pass: assert property (p_six_pass)
    else $error("fp condition class dropped");

endmodule
`default_nettype wire

// >>> bench/sfpx_unit_bench.sv
/*
 Self-checking bench of the SIMD fp exception unit.
 Assumes the unit, its package and the constants header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfpx_defines.svh"

module sfpx_unit_bench;
  logic                  clk = 1'h0;
  logic                  rst_n = 1'h0;
  logic [7:0]            awaddr = 8'h00;
  logic [7:0]            araddr = 8'h00;
  logic                  awvalid = 1'h0;
  logic                  wvalid = 1'h0;
  logic                  bready = 1'h0;
  logic                  arvalid = 1'h0;
  logic                  rready = 1'h0;
  logic [31:0]           wdata = 32'h0;
  logic [31:0]           opnd = 32'h0;
  logic                  awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]            bresp, rresp, rsp;
  logic [31:0]           rdata, store, flushed, rd;
  sfpx_pkg::sfpx_cmpl_s  cmpl = '0;
  sfpx_pkg::sfpx_load_s  ld = '0;
  sfpx_pkg::sfpx_fault_s fault;
  int                    errors = 0;
  int                    num_checks = 0;
  int                    seed = 52430;
  logic [5:0]            flg = 6'h00;
  logic [5:0]            msk = 6'h3f;
  logic [2:0]            irqst = 3'h0;
  logic [2:0]            imsk = 3'h0;
  logic                  os = 1'h0;
  logic                  daz = 1'h0;

  sfpx_unit sfpx_unit_i (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .CMPL_IN(cmpl), .CORE_LOAD_IN(ld),
    .CORE_STORE_OUT(store), .SRC_OPND_IN(opnd),
    .SRC_FLUSHED_OUT(flushed), .FAULT_OUT(fault), .IRQ_OUT(irq)
  );

  always #20 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait on a sampled handshake; a hang ends the run
  task automatic hold(input string what, ref logic sig);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        errors++;
        $display("FAIL %s expected answer seen timeout", what);
        print_verdict();
      end
    end while (sig !== 1'h1);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    hold("awready", awready);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    hold("bvalid", bvalid);
    rsp = bresp;
    bready <= 1'h0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    hold("arready", arready);
    arvalid <= 1'h0;
    hold("rvalid", rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask

  function automatic logic [31:0] ctrl_word();
    return {19'h0, msk, daz, flg};
  endfunction

  // xf, ud, nonnum, wb_en as the fault struct packs them
  function automatic logic [3:0] exp_fault(input logic [1:0] k,
      input logic [5:0] c, input logic nn);
    logic [5:0] um;
    um = (k == 2'h1 && !nn) ? (c & ~msk) : 6'h00;
    return {(|um) & os, (|um) & !os, nn, !(nn | um[0])};
  endfunction

  function automatic logic [31:0] flush(input logic [31:0] v);
    return (daz && v[30:23] == 8'h00) ? {v[31], 31'h0} : v;
  endfunction

  task automatic fire(input logic [1:0] k, input logic [5:0] c,
      input logic nn);
    logic [3:0] ef;
    ef = exp_fault(k, c, nn);
    @(posedge clk);
    cmpl <= '{1'h1, sfpx_pkg::sfpx_kind_e'(k), c, nn};
    @(posedge clk);
    cmpl.valid <= 1'h0;
    #1;
    if (k == 2'h1 && !nn) flg = flg | c;
    irqst = irqst | {nn, ef[2], ef[3]};
    chk("fault", {28'h0, ef}, {28'h0, fault});
    chk("flags", ctrl_word(), store);
    chk("irq", {31'h0, |(irqst & imsk)}, {31'h0, irq});
  endtask

  task automatic cload(input logic [5:0] m, input logic z);
    @(posedge clk);
    ld <= '{1'h1, {19'h0, m, z, flg}};
    @(posedge clk);
    ld.en <= 1'h0;
    #1;
    msk = m;
    daz = z;
    chk("store", ctrl_word(), store);
  endtask

  task automatic set_os(input logic o);
    os = o;
    axw(`SFPX_OFF_SYSC4, {21'h0, o, 10'h0});
    chk("os bresp", 32'h0, {30'h0, rsp});
  endtask

  initial begin
    logic [31:0] v;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    chk("store rst", 32'h00001f80, store);
    axr(8'h40);
    chk("unmapped rresp", 32'h2, {30'h0, rsp});
    chk("unmapped rdata", 32'h0, rd);
    axw(8'h44, 32'hffffffff);
    chk("unmapped bresp", 32'h2, {30'h0, rsp});
    set_os(1'h1);
    axr(`SFPX_OFF_SYSC4);
    chk("os bit", 32'h00000400, rd);
    imsk = 3'h7;
    axw(`SFPX_OFF_IRQ_MSK, 32'h7);
    // each class alone, unmasked then masked
    for (int i = 0; i < 6; i++) begin
      cload(~(6'h01 << i), 1'h0);
      fire(2'h1, 6'h01 << i, 1'h0);
      cload(6'h3f, 1'h0);
      fire(2'h1, 6'h01 << i, 1'h0);
    end
    chk("inv den bits", 32'h00001f83, store & 32'h00001f83);
    cload(6'h3e, 1'h0);
    set_os(1'h0);
    fire(2'h1, 6'h01, 1'h0);
    set_os(1'h1);
    cload(6'h00, 1'h0);
    fire(2'h1, 6'h02, 1'h0);
    fire(2'h0, 6'h3f, 1'h0);
    fire(2'h2, 6'h3f, 1'h0);
    fire(2'h3, 6'h3f, 1'h0);
    fire(2'h1, 6'h3f, 1'h1);
    fire(2'h1, 6'h3f, 1'h0);
    axr(`SFPX_OFF_CTRL);
    chk("ctrl read", ctrl_word(), rd);
    chk("ctrl rresp", 32'h0, {30'h0, rsp});
    axr(`SFPX_OFF_IRQ_ST);
    chk("irq status", {29'h0, irqst}, rd);
    irqst = 3'h0;
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    flg = 6'h00;
    msk = 6'h15;
    axw(`SFPX_OFF_CTRL, ctrl_word());
    axr(`SFPX_OFF_CTRL);
    chk("flags cleared", ctrl_word(), rd);
    // operand flush with and without the zero control
    for (int z = 0; z < 2; z++) begin
      cload(msk, z[0]);
      for (int j = 0; j < 6; j++) begin
        v = $random(seed);
        if (j < 3) v[30:23] = 8'h00;
        if (j == 0) v[22:0] = 23'h0;
        @(posedge clk);
        opnd <= v;
        @(posedge clk);
        #1;
        chk("flushed", flush(v), flushed);
      end
    end
    // random traffic; irq mask and os bit move too
    for (int r = 0; r < 60; r++) begin
      if (r % 10 == 0) begin
        set_os($random(seed));
        imsk = $random(seed);
        axw(`SFPX_OFF_IRQ_MSK, {29'h0, imsk});
      end
      cload($random(seed), 1'h0);
      fire($random(seed), $random(seed), ($random(seed) % 8) == 0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
